//--- liu_alarm_status_map.vh
// register map and constants for the line alarm status block
// Notes on behaviour
// - no pulse for 128 bit periods raises alarm
// - any pulse clears alarm at once
// - bit 6 read-only alarm, resets zero
// - alarm change with enable requests interrupt
// - bit 5 read-only fifo limit flag
// - fifo flag change with enable requests interrupt
// - bits 7 and 4 always read zero
`ifndef LIU_ALARM_STATUS_MAP_VH
`define LIU_ALARM_STATUS_MAP_VH
// byte addresses on the register bus
`define ADDR_STATUS 4'h0
`define ADDR_IRQ_ENABLE 4'h4
`define ADDR_IRQ_PENDING 4'h8
// bit positions
`define BIT_DRV_MON 6
`define BIT_FIFO_LIM 5
// silent bit periods before the alarm
`define DRV_MON_PERIODS 8'd128
// allowed pointer distance for the fifo limit flag
`define FIFO_LIM_DIST 3
// bus response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- liu_alarm_status_bits.v
// line alarm status bits with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "liu_alarm_status_map.vh"
module liu_alarm_status_bits #(
   parameter PTR_W = 4
)(
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // write address channel
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // write data channel
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // write response channel
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // read address channel
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // read data channel
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // transmit line monitor, sampled from pins
   input wire tx_bit_tick,
   input wire tx_line_pos,
   input wire tx_line_neg,
   // jitter attenuator pointers, same clock
   input wire [PTR_W-1:0] ja_wr_ptr,
   input wire [PTR_W-1:0] ja_rd_ptr,
   // interrupt request to the combiner
   output reg irq_req
);

   // pin synchronisers: stage one feeds stage two only
   reg [2:0] pin_s1_reg;
   reg [2:0] pin_s2_reg;
   reg tick_d_reg; // previous synced tick for edge detect
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         tick_d_reg <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= {tx_bit_tick, tx_line_pos, tx_line_neg};
         pin_s2_reg <= pin_s1_reg;
         tick_d_reg <= pin_s2_reg[2];
      end
   end

   wire bit_period; // one cycle per transmit bit period
   wire pulse_seen; // bipolar activity on either rail
   assign bit_period = pin_s2_reg[2] & ~tick_d_reg;
   assign pulse_seen = pin_s2_reg[1] | pin_s2_reg[0];

   // silent period counter and driver monitor alarm
   reg [7:0] silent_reg;
   reg drv_mon_reg; // driver_monitor_alarm
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         silent_reg <= 8'h00;
         drv_mon_reg <= 1'b0;
      end
      else if (pulse_seen)
      begin
         // any activity ends the alarm with no qualification
         silent_reg <= 8'h00;
         drv_mon_reg <= 1'b0;
      end
      else if (bit_period)
      begin
         if (silent_reg == `DRV_MON_PERIODS - 8'd1)
            drv_mon_reg <= 1'b1;
         else
            silent_reg <= silent_reg + 8'd1;
      end
   end

   // fifo limit flag from pointer distance, in both directions
   function [PTR_W-1:0] ptr_dist;
      input [PTR_W-1:0] a;
      input [PTR_W-1:0] b;
      reg [PTR_W-1:0] d;
      begin
         d = a - b;
         ptr_dist = (d[PTR_W-1]) ? (b - a) : d;
      end
   endfunction

   reg fifo_lim_reg; // fifo_limit_flag
   always @(posedge aclk)
   begin
      if (!aresetn)
         fifo_lim_reg <= 1'b0;
      else
         // widen the distance so the limit compares at full width
         fifo_lim_reg <= ({{(32-PTR_W){1'b0}},
                           ptr_dist(ja_wr_ptr, ja_rd_ptr)} <=
                          `FIFO_LIM_DIST);
   end

   // change detection and pending interrupt bits
   reg drv_mon_d_reg;
   reg fifo_lim_d_reg;
   reg [1:0] irq_en_reg; // {driver monitor, fifo limit} enables
   reg [1:0] pend_reg; // sticky change flags, write one to clear
   wire [1:0] change;
   wire [1:0] pend_clr;
   wire wr_fire;
   assign change = {drv_mon_reg ^ drv_mon_d_reg,
                    fifo_lim_reg ^ fifo_lim_d_reg};
   // set wins over clear so a change in the clear cycle survives
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         drv_mon_d_reg <= 1'b0;
         fifo_lim_d_reg <= 1'b0;
         pend_reg <= 2'b00;
         irq_req <= 1'b0;
      end
      else
      begin
         drv_mon_d_reg <= drv_mon_reg;
         fifo_lim_d_reg <= fifo_lim_reg;
         pend_reg <= (pend_reg & ~pend_clr) | (change & irq_en_reg);
         irq_req <= |(pend_reg & irq_en_reg);
      end
   end

   // axi write: address and data taken in either order
   reg aw_full_reg;
   reg w_full_reg;
   reg [3:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign pend_clr = (wr_fire && aw_addr_reg == `ADDR_IRQ_PENDING &&
                      w_strb_reg[0]) ?
                     {w_data_reg[`BIT_DRV_MON], w_data_reg[`BIT_FIFO_LIM]}
                     : 2'b00;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         irq_en_reg <= 2'b00;
      end
      else
      begin
         // ready follows a seen request by one cycle, never idles high
         s_axi_awready <= s_axi_awvalid & ~aw_full_reg & ~s_axi_awready;
         s_axi_wready <= s_axi_wvalid & ~w_full_reg & ~s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            // status register is read only; writes to it are refused
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (aw_addr_reg == `ADDR_IRQ_ENABLE)
            begin
               if (w_strb_reg[0])
                  irq_en_reg <= {w_data_reg[`BIT_DRV_MON],
                                 w_data_reg[`BIT_FIFO_LIM]};
            end
            else if (aw_addr_reg != `ADDR_IRQ_PENDING)
               s_axi_bresp <= `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
         end
      end
   end

   // axi read: one outstanding read, answer two cycles after arvalid
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0; // bits 7 and 4 stay zero
         case (s_axi_araddr)
            `ADDR_STATUS:
            begin
               s_axi_rdata[`BIT_DRV_MON] <= drv_mon_reg;
               s_axi_rdata[`BIT_FIFO_LIM] <= fifo_lim_reg;
            end
            `ADDR_IRQ_ENABLE:
            begin
               s_axi_rdata[`BIT_DRV_MON] <= irq_en_reg[1];
               s_axi_rdata[`BIT_FIFO_LIM] <= irq_en_reg[0];
            end
            `ADDR_IRQ_PENDING:
            begin
               s_axi_rdata[`BIT_DRV_MON] <= pend_reg[1];
               s_axi_rdata[`BIT_FIFO_LIM] <= pend_reg[0];
            end
            default:
               s_axi_rresp <= `RESP_SLVERR;
         endcase
      end
      else
         s_axi_arready <= s_axi_arvalid;
   end

endmodule // liu_alarm_status_bits

//--- liu_alarm_status_monitor.sv
// port assertions for the line alarm status block
`include "liu_alarm_status_map.vh"
module liu_alarm_status_monitor (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // write side
   input logic [3:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   // read side
   input logic [3:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // answers must hold until the master takes them
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no read answer");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("no write answer");
   // ready is only offered once a request is seen
   aw_cause_a: assert property ($rose(s_axi_awready) |->
      $past(s_axi_awvalid)) else $error("awready without request");
   reserved_zero_a: assert property (s_axi_rvalid |->
      !s_axi_rdata[7] && !s_axi_rdata[4]) else $error("reserved bit set");
   status_write_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready && s_axi_awaddr == `ADDR_STATUS |->
      ##[1:2] s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)
      else $error("status write not refused");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == 4'hc |=> s_axi_rresp == `RESP_SLVERR &&
      s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule // liu_alarm_status_monitor

//--- test_liu_alarm_status_bits.sv
// testbench for the line alarm status block
`include "liu_alarm_status_map.vh"
module test_liu_alarm_status_bits;
   timeunit 1ns;
   timeprecision 1ps;
   // stimulus driven by the bench and responses from the DUT, named as the ports
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, tx_bit_tick, tx_line_pos, tx_line_neg;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, ja_wr_ptr, ja_rd_ptr;
   logic [31:0] s_axi_wdata;
   wire [31:0] s_axi_rdata;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid, irq_req;
   int bad_count = 0;
   int checked = 0;
   // write pointer steps: flag toggles every step, wrap case included
   logic [3:0] wp [4] = '{4'h4, 4'hd, 4'hc, 4'h3};
   liu_alarm_status_bits #(.PTR_W(4)) DUT (.*);
   initial
   begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one write; address and data offered together, each dropped when taken
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      logic pa, pd;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      pa = 1;
      pd = 1;
      while (pa | pd)
      begin
         @(posedge aclk);
         pa = pa & !s_axi_awready;
         pd = pd & !s_axi_wready;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pd;
      end
      do
         @(posedge aclk);
      while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, e});
      s_axi_bready <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do
         @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do
         @(posedge aclk);
      while (!s_axi_rvalid);
      chk(s_axi_rdata, x);
      chk({30'h0, s_axi_rresp}, {30'h0, e});
      s_axi_rready <= 0;
   endtask
   // bit periods on a silent line, eight system clocks each
   task tk(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge aclk);
         tx_bit_tick <= 1;
         repeat (4) @(posedge aclk);
         tx_bit_tick <= 0;
      end
   endtask
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
      {s_axi_rready, tx_bit_tick, tx_line_pos, tx_line_neg, aresetn} = 0;
      {s_axi_awaddr, s_axi_araddr, ja_wr_ptr, ja_rd_ptr} = 0;
      s_axi_wdata = 0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd(`ADDR_STATUS, 32'h20, `RESP_OKAY);
      rd(`ADDR_IRQ_PENDING, 32'h0, `RESP_OKAY);
      wr(`ADDR_IRQ_ENABLE, 32'hff, `RESP_OKAY);
      rd(`ADDR_IRQ_ENABLE, 32'h60, `RESP_OKAY);
      wr(`ADDR_STATUS, 32'hff, `RESP_SLVERR);
      rd(`ADDR_STATUS, 32'h20, `RESP_OKAY);
      rd(4'hc, 32'h0, `RESP_SLVERR);
      wr(4'hc, 32'h0, `RESP_SLVERR);
      // alarm raised on silence, then lifted by a pulse on each rail
      for (int r = 0; r < 2; r++)
      begin
         tk(127);
         rd(`ADDR_STATUS, 32'h20, `RESP_OKAY);
         tk(1);
         rd(`ADDR_STATUS, 32'h60, `RESP_OKAY);
         chk({31'h0, irq_req}, 32'h1);
         wr(`ADDR_IRQ_PENDING, 32'h40, `RESP_OKAY);
         tx_line_pos <= !r[0];
         tx_line_neg <= r[0];
         repeat (4) @(posedge aclk);
         {tx_line_pos, tx_line_neg} <= 2'b00;
         rd(`ADDR_STATUS, 32'h20, `RESP_OKAY);
         rd(`ADDR_IRQ_PENDING, 32'h40, `RESP_OKAY);
         wr(`ADDR_IRQ_PENDING, 32'h40, `RESP_OKAY);
      end
      // pointer distance across the limit, both directions
      for (int i = 0; i < 4; i++)
      begin
         ja_wr_ptr <= wp[i];
         repeat (3) @(posedge aclk);
         rd(`ADDR_STATUS, {26'h0, i[0], 5'h0}, `RESP_OKAY);
         rd(`ADDR_IRQ_PENDING, 32'h20, `RESP_OKAY);
         chk({31'h0, irq_req}, 32'h1);
         wr(`ADDR_IRQ_PENDING, 32'h20, `RESP_OKAY);
      end
      // with enables off a change leaves nothing pending
      wr(`ADDR_IRQ_ENABLE, 32'h0, `RESP_OKAY);
      ja_wr_ptr <= 4'h4;
      repeat (3) @(posedge aclk);
      rd(`ADDR_IRQ_PENDING, 32'h0, `RESP_OKAY);
      chk({31'h0, irq_req}, 32'h0);
      // a write without the low byte lane leaves the enables alone
      s_axi_wstrb <= 4'he;
      wr(`ADDR_IRQ_ENABLE, 32'hff, `RESP_OKAY);
      rd(`ADDR_IRQ_ENABLE, 32'h0, `RESP_OKAY);
      tally_and_finish;
   end
   // hang guard, several times the expected run
   initial
   begin
      #100us;
      bad_count++;
      tally_and_finish;
   end
endmodule // test_liu_alarm_status_bits
bind liu_alarm_status_bits liu_alarm_status_monitor mon (.*);
